// *** src/clf_top.sv ***
// ============================================================
// current limit lock reaction with avalon-mm registers
//
// The register addresses and the Avalon-MM interface to the registers were left to the implementer.
module clf_top
  import clf_pkg::*;
#(
  parameter int unsigned RETRY_UNIT_CYCLES = RETRY_UNIT_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // avalon-mm slave
  input wire logic [3:0] address,
  input wire logic [3:0] byteenable,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // current comparator pin
  input wire logic lockCompRaw,
  // fault and bridge
  output logic faultIndicatorPin_b,
  output clf_bridge_e bridgeState,
  output logic detectDisabled,
  output logic [7:0] absentMotorThreshold
);

  // ==========================================================
  // declarations
  clf_if lnk ();
  clf_state_e state;
  logic [31:0] configReg;
  logic [31:0] retryReg;
  logic [31:0] beMask;
  logic [31:0] statusWord;
  logic [3:0] currentLimitLockAction;
  logic [2:0] currentLimitLockFilterTime;
  logic [2:0] absentMotorCurrentThreshold;
  logic [3:0] lockRetryInterval;
  logic [3:0] retryCountLimit;
  logic [3:0] retryCount;
  logic [1:0] reactCode;
  logic [31:0] retryTimer;
  logic [31:0] retryLoad;
  logic acceptWr;
  logic clearReq;
  logic detectOn;
  logic lockHit;
  logic goLatch;
  clf_bridge_e next_bridgeState;

  // ==========================================================
  // event filter
  clf_filter i_clf_filter (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .lockCompRaw(lockCompRaw),
    .lnk(lnk)
  );

  assign lnk.filterCode = currentLimitLockFilterTime;
  assign lnk.detectEnable = detectOn;

  // ==========================================================
  // field views
  assign currentLimitLockAction = configReg[ACT_LSB +: 4];
  assign currentLimitLockFilterTime = configReg[FILT_LSB +: 3];
  assign absentMotorCurrentThreshold = configReg[THR_LSB +: 3];
  assign lockRetryInterval = retryReg[RINT_LSB +: 4];
  assign retryCountLimit = retryReg[RLIM_LSB +: 4];

  // codes 8h and up switch detection off
  assign detectOn = !currentLimitLockAction[3];
  // second gate here so a pulse in flight when disabled is dropped
  assign lockHit = lnk.lockEvent && detectOn;

  // latched codes, or retries used up
  assign goLatch = !currentLimitLockAction[2] || (retryCount >= retryCountLimit);

  // retry accounting:
  // - the budget counts finished retry waits, not events
  // - a limit of 0h means the first event in a retry code latches at once
  // - the count only starts again on a software clear of a latched fault,
  //   so a motor that locks now and then slowly uses up its budget; this
  //   was traded for not needing a second timer to age the count out
  // - editing the action field during a wait does not shorten that wait
  // retry interval is (code + 1) units
  assign retryLoad = 32'((32'(lockRetryInterval) + 32'h1) * RETRY_UNIT_CYCLES);

  // ==========================================================
  // register map, word aligned byte addresses
  // 0h config, read-write
  //   [21:19] absent motor threshold code
  //   [18:15] action code: 0h-3h latch, 4h-7h retry, 8h-fh detection off
  //   [14:12] lock filter time code, 0h none, else one unit per step
  //   [11]    spare, read-write, no effect
  // 4h retry setup, read-write
  //   [3:0]   retry interval code, wait is (code + 1) units
  //   [7:4]   retry count limit
  // 8h status, read-only, writes ignored
  //   [0]     fault latched
  //   [1]     retry wait running
  //   [2]     detection off
  //   [7:4]   retries used so far
  //   [10:8]  bridge state
  //   [23:16] decoded threshold in 1/128 A
  // ch control, write-only, reads zero
  //   [0]     write 1 to clear a latched fault
  // unmapped addresses read zero and ignore writes

  // ==========================================================
  // bus handshake
  // one wait cycle: request seen with waitrequest high, answer next edge
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      waitrequest <= 1'b1;
    end else if ((read || write) && waitrequest) begin
      waitrequest <= 1'b0;
    end else begin
      waitrequest <= 1'b1;
    end
  end

  // a write lands only at the edge where waitrequest is seen low
  assign acceptWr = write && !waitrequest;
  assign beMask = {{8{byteenable[3]}}, {8{byteenable[2]}},
                   {8{byteenable[1]}}, {8{byteenable[0]}}};
  assign clearReq = acceptWr && (address == OFS_CONTROL) &&
                    byteenable[0] && writedata[CTRL_CLEAR_BIT];

  // ==========================================================
  // configuration registers
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      configReg <= CONFIG_RESET;
    end else if (acceptWr && (address == OFS_CONFIG)) begin
      configReg <= (configReg & ~(beMask & CONFIG_RW_MASK)) |
                   (writedata & beMask & CONFIG_RW_MASK);
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      retryReg <= RETRY_RESET;
    end else if (acceptWr && (address == OFS_RETRY)) begin
      retryReg <= (retryReg & ~(beMask & RETRY_RW_MASK)) |
                  (writedata & beMask & RETRY_RW_MASK);
    end
  end

  // ==========================================================
  // status word and read data
  always_comb begin
    statusWord = 32'h0;
    statusWord[ST_LATCH_BIT] = (state == ST_LATCH);
    statusWord[ST_WAIT_BIT] = (state == ST_RETRY);
    statusWord[ST_DIS_BIT] = !detectOn;
    statusWord[ST_CNT_LSB +: 4] = retryCount;
    statusWord[ST_BRIDGE_LSB +: 3] = bridgeState;
    statusWord[ST_THR_LSB +: 8] = absentMotorThreshold;
  end

  // data captured when the answer is raised, held through the accept edge
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      readdata <= 32'h0;
    end else if (read && waitrequest) begin
      case (address)
        OFS_CONFIG: readdata <= configReg;
        OFS_RETRY: readdata <= retryReg;
        OFS_STATUS: readdata <= statusWord;
        default: readdata <= 32'h0; // control and unmapped read zero
      endcase
    end
  end

  // ==========================================================
  // reaction state machine
  // events while waiting out a retry are ignored: bridge is already off
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (lockHit) begin
            state <= goLatch ? ST_LATCH : ST_RETRY;
          end
        end
        ST_RETRY: begin
          if (retryTimer == 32'h0) begin
            state <= ST_IDLE;
          end
        end
        ST_LATCH: begin
          // a new event in the clear cycle keeps the fault: set wins
          if (clearReq && !lockHit) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // reaction captured at the event so later code edits cannot move it
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      reactCode <= 2'h0;
    end else if (lockHit && (state != ST_RETRY)) begin
      reactCode <= currentLimitLockAction[1:0];
    end
  end

  // retry wait timer
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      retryTimer <= 32'h0;
    end else if ((state == ST_IDLE) && lockHit) begin
      retryTimer <= retryLoad;
    end else if ((state == ST_RETRY) && (retryTimer != 32'h0)) begin
      retryTimer <= retryTimer - 32'h1;
    end
  end

  // retries so far; only a software clear starts the budget again
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      retryCount <= 4'h0;
    end else if ((state == ST_RETRY) && (retryTimer == 32'h0)) begin
      retryCount <= retryCount + 4'h1;
    end else if ((state == ST_LATCH) && clearReq && !lockHit) begin
      retryCount <= 4'h0;
    end
  end

  // ==========================================================
  // registered outputs
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      faultIndicatorPin_b <= 1'b1;
    end else begin
      faultIndicatorPin_b <= (state != ST_LATCH);
    end
  end

  // bridge follows the captured code while a fault or retry stands
  always_comb begin
    next_bridgeState = BR_DRIVE;
    if (state != ST_IDLE) begin
      case (reactCode)
        2'h0: begin
          next_bridgeState = BR_TRISTATE;
        end
        2'h1: begin
          next_bridgeState = BR_RECIRC;
        end
        2'h2: begin
          next_bridgeState = BR_HIGH_BRAKE;
        end
        default: begin
          next_bridgeState = BR_LOW_BRAKE;
        end
      endcase
    end
  end

  // registered so the gate drive never sees a decode glitch
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      bridgeState <= BR_DRIVE;
    end else begin
      bridgeState <= next_bridgeState;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      detectDisabled <= 1'b0;
    end else begin
      detectDisabled <= !detectOn;
    end
  end

  // code 7h gives 0.625 A
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      absentMotorThreshold <= 8'h04;
    end else begin
      absentMotorThreshold <= THR_TABLE[absentMotorCurrentThreshold];
    end
  end

endmodule // clf_top

// *** shared/clf_pkg.sv ***
package clf_pkg;

  // ==========================================================
  // register map (byte addresses)
  localparam logic [3:0] OFS_CONFIG = 4'h0;
  localparam logic [3:0] OFS_RETRY = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h8;
  localparam logic [3:0] OFS_CONTROL = 4'hc;

  // ==========================================================
  // config fields
  localparam int THR_LSB = 19;
  localparam int ACT_LSB = 15;
  localparam int FILT_LSB = 12;
  localparam logic [31:0] CONFIG_RW_MASK = 32'h003ff800;
  localparam logic [31:0] CONFIG_RESET = 32'h00000000;

  // retry fields
  localparam int RINT_LSB = 0;
  localparam int RLIM_LSB = 4;
  localparam logic [31:0] RETRY_RW_MASK = 32'h000000ff;
  localparam logic [31:0] RETRY_RESET = 32'h00000000;

  // control and status fields
  localparam int CTRL_CLEAR_BIT = 0;
  localparam int ST_LATCH_BIT = 0;
  localparam int ST_WAIT_BIT = 1;
  localparam int ST_DIS_BIT = 2;
  localparam int ST_CNT_LSB = 4;
  localparam int ST_BRIDGE_LSB = 8;
  localparam int ST_THR_LSB = 16;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int FILTER_UNIT_NS = 1000;
  localparam logic [7:0] FILTER_UNIT_CYC =
    8'((FILTER_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int RETRY_UNIT_MS = 100;
  localparam int unsigned RETRY_UNIT_CYC = RETRY_UNIT_MS * (1000000 / CLK_PERIOD_NS);

  // ==========================================================
  // absent motor threshold, in units of 1/128 A
  localparam logic [7:0] THR_TABLE [8] = '{
    8'h04, 8'h06, 8'h08, 8'h0a, 8'h14, 8'h28, 8'h3c, 8'h50
  };

  // bridge output states
  typedef enum logic [2:0] {
    BR_DRIVE = 3'h0,
    BR_TRISTATE = 3'h1,
    BR_RECIRC = 3'h2,
    BR_HIGH_BRAKE = 3'h3,
    BR_LOW_BRAKE = 3'h4
  } clf_bridge_e;

  // reaction states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RETRY = 3'b010,
    ST_LATCH = 3'b100
  } clf_state_e;

endpackage

// *** shared/clf_if.sv ***
// ============================================================
// link between register core and lock event filter
interface clf_if;
  logic [2:0] filterCode;
  logic detectEnable;
  logic lockEvent;

  modport core (
    output filterCode,
    output detectEnable,
    input lockEvent
  );

  modport filt (
    input filterCode,
    input detectEnable,
    output lockEvent
  );
endinterface

// *** src/clf_filter.sv ***
// ============================================================
// comparator sync, deglitch and edge pulse
module clf_filter
  import clf_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // raw comparator pin
  input wire logic lockCompRaw,
  // core side
  clf_if.filt lnk
);

  logic syncA;
  logic syncB;
  logic syncC;
  logic stableLevel;
  logic filtered;
  logic filteredDly;
  logic [7:0] holdCnt;
  logic [7:0] filterLen;

  // three stages; only syncB reads syncA
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      syncA <= 1'b0;
      syncB <= 1'b0;
      syncC <= 1'b0;
    end else begin
      syncA <= lockCompRaw;
      syncB <= syncA;
      syncC <= syncB;
    end
  end

  // a change counts once the last two stages agree
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      stableLevel <= 1'b0;
    end else if (syncB == syncC) begin
      stableLevel <= syncC;
    end
  end

  assign filterLen = 8'(lnk.filterCode * FILTER_UNIT_CYC);

  // level must stay high for the whole filter time
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      holdCnt <= 8'h00;
      filtered <= 1'b0;
    end else if (!stableLevel) begin
      holdCnt <= 8'h00;
      filtered <= 1'b0;
    end else if (holdCnt >= filterLen) begin
      filtered <= 1'b1;
    end else begin
      holdCnt <= holdCnt + 8'h01;
    end
  end

  // one pulse per lock event, none while disabled
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      filteredDly <= 1'b0;
      lnk.lockEvent <= 1'b0;
    end else begin
      filteredDly <= filtered;
      lnk.lockEvent <= filtered && !filteredDly && lnk.detectEnable;
    end
  end

endmodule // clf_filter

// *** verification/clf_top_chk.sv ***
// ==========================================================
// port checker for the lock reaction block
module clf_top_chk
  import clf_pkg::*;
#(
  parameter int unsigned RETRY_UNIT_CYCLES = 10
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // bus
  input wire logic [3:0] address,
  input wire logic [3:0] byteenable,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic waitrequest,
  // outputs
  input wire logic faultIndicatorPin_b,
  input wire clf_bridge_e bridgeState,
  input wire logic detectDisabled,
  input wire logic [7:0] absentMotorThreshold
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  logic cfgWr;
  logic ctrlWr;
  logic [2:0] thrCode;
  logic [3:0] actCode;

  // accepted writes; config writes full word only so every field lane is present
  assign cfgWr = write && !waitrequest && address == OFS_CONFIG && byteenable == 4'hf;
  assign ctrlWr = write && !waitrequest && address == OFS_CONTROL && byteenable[0] && writedata[0];

  // remember the fields of the last accepted config write
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      thrCode <= 3'h0;
      actCode <= 4'h0;
    end else if (cfgWr) begin
      thrCode <= writedata[21:19];
      actCode <= writedata[18:15];
    end
  end

  chk_wait_one: assert property ((read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
    else $error("bus answer not exactly one wait");
  chk_pin_bridge: assert property (!faultIndicatorPin_b |-> bridgeState != BR_DRIVE)
    else $error("fault latched with bridge driving");
  chk_latch_hold: assert property ($rose(faultIndicatorPin_b) |-> $past(ctrlWr, 2))
    else $error("fault pin released without clear");
  chk_retry_end: assert property (faultIndicatorPin_b && bridgeState != BR_DRIVE |-> ##[1:200] bridgeState == BR_DRIVE)
    else $error("retry did not resume");
  chk_thr_code: assert property (cfgWr |-> ##2 absentMotorThreshold == THR_TABLE[thrCode])
    else $error("threshold decode wrong");
  chk_dis_cfg: assert property (cfgWr |-> ##2 detectDisabled == actCode[3])
    else $error("disable flag wrong");
  chk_dis_pin: assert property (detectDisabled && faultIndicatorPin_b |=> faultIndicatorPin_b)
    else $error("fault while disabled");
  chk_dis_bridge: assert property (detectDisabled && bridgeState == BR_DRIVE |=> bridgeState == BR_DRIVE)
    else $error("bridge moved while disabled");
endmodule // clf_top_chk

// *** verification/clf_top_tb.sv ***
// ==========================================================
// self-checking bench for the lock reaction block
module clf_top_tb;
  import clf_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  // short retry unit keeps the run brief
  localparam int unsigned UNIT = 10;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic lockCompRaw = 1'b0;
  logic [3:0] address = 4'h0;
  logic [3:0] byteenable = 4'h0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic [31:0] q;
  logic waitrequest;
  logic faultIndicatorPin_b;
  logic detectDisabled;
  logic [7:0] absentMotorThreshold;
  clf_bridge_e bridgeState;
  int nErrors = 0;
  int nTests = 0;
  // threshold in 1/128 A and bridge per code, taken from the field encodings
  logic [7:0] thr [8] = '{8'h04, 8'h06, 8'h08, 8'h0a, 8'h14, 8'h28, 8'h3c, 8'h50};
  clf_bridge_e br [4] = '{BR_TRISTATE, BR_RECIRC, BR_HIGH_BRAKE, BR_LOW_BRAKE};

  clf_top #(.RETRY_UNIT_CYCLES(UNIT)) i_clf_top (
    .core_clk(core_clk), .rst_b(rst_b), .address(address), .byteenable(byteenable),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .lockCompRaw(lockCompRaw),
    .faultIndicatorPin_b(faultIndicatorPin_b), .bridgeState(bridgeState),
    .detectDisabled(detectDisabled), .absentMotorThreshold(absentMotorThreshold)
  );

  // ==========================================================
  // clock
  always #20 core_clk = ~core_clk;

  task summarize();
    if (nErrors == 0 && nTests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    nTests++;
    if (g !== e) begin
      nErrors++;
      $display("mismatch %s exp %h got %h", s, e, g);
    end
  endtask

  // one avalon transfer; holds everything until waitrequest is seen low
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    address <= a;
    writedata <= d;
    byteenable <= 4'hf;
    read <= !w;
    write <= w;
    do begin
      @(posedge core_clk);
    end while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge core_clk);
  endtask

  // comparator pulse of h cycles, then time for the reaction to land
  task ev(input int h);
    lockCompRaw <= 1'b1;
    repeat (h) @(posedge core_clk);
    lockCompRaw <= 1'b0;
    repeat (12) @(posedge core_clk);
  endtask

  task clr();
    bus(1'b1, OFS_CONTROL, 32'h1);
    repeat (3) @(posedge core_clk);
  endtask

  // ==========================================================
  // scenarios
  task t_regs();
    bus(1'b0, OFS_CONFIG, 32'h0);
    chk("config reset", 32'h0, q);
    bus(1'b1, OFS_CONFIG, 32'hffffffff);
    bus(1'b0, OFS_CONFIG, 32'h0);
    chk("config rw", 32'h003ff800, q);
    bus(1'b0, 4'h2, 32'h0);
    chk("unmapped", 32'h0, q);
  endtask

  task t_thr();
    for (int c = 0; c < 8; c++) begin
      bus(1'b1, OFS_CONFIG, 32'(c) << 19);
      repeat (2) @(posedge core_clk);
      chk("threshold", 32'(thr[c]), 32'(absentMotorThreshold));
    end
  endtask

  task t_latch();
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, OFS_CONFIG, 32'(c) << 15);
      ev(3);
      chk("pin", 32'h0, 32'(faultIndicatorPin_b));
      chk("bridge", 32'(br[c]), 32'(bridgeState));
      ev(3);
      chk("pin held", 32'h0, 32'(faultIndicatorPin_b));
      clr();
      chk("pin clear", 32'h1, 32'(faultIndicatorPin_b));
      chk("bridge clear", 32'(BR_DRIVE), 32'(bridgeState));
    end
  endtask

  // interval code 2, limit 1: one retry, then the next event latches
  task t_retry();
    bus(1'b1, OFS_RETRY, 32'h12);
    for (int c = 4; c < 8; c++) begin
      bus(1'b1, OFS_CONFIG, 32'(c) << 15);
      ev(3);
      chk("retry pin", 32'h1, 32'(faultIndicatorPin_b));
      chk("retry bridge", 32'(br[c - 4]), 32'(bridgeState));
      bus(1'b0, OFS_STATUS, 32'h0);
      chk("status wait", 32'h2, q & 32'h7);
      repeat (40) @(posedge core_clk);
      chk("resume", 32'(BR_DRIVE), 32'(bridgeState));
      ev(3);
      chk("limit pin", 32'h0, 32'(faultIndicatorPin_b));
      chk("limit bridge", 32'(br[c - 4]), 32'(bridgeState));
      bus(1'b0, OFS_STATUS, 32'h0);
      chk("status latch", 32'h1, q & 32'h7);
      chk("status count", 32'h1, (q >> ST_CNT_LSB) & 32'hf);
      clr();
    end
  endtask

  task t_dis();
    for (int c = 8; c < 16; c++) begin
      bus(1'b1, OFS_CONFIG, 32'(c) << 15);
      repeat (2) @(posedge core_clk);
      chk("disabled", 32'h1, 32'(detectDisabled));
      ev(3);
      chk("dis pin", 32'h1, 32'(faultIndicatorPin_b));
      chk("dis bridge", 32'(BR_DRIVE), 32'(bridgeState));
    end
    bus(1'b1, OFS_CONFIG, 32'h0);
    repeat (2) @(posedge core_clk);
    chk("enabled", 32'h0, 32'(detectDisabled));
  endtask

  // filter 1h is 25 cycles: a 10 cycle glitch is dropped, 40 cycles is not
  task t_filt();
    bus(1'b1, OFS_CONFIG, 32'h1000);
    ev(10);
    chk("glitch", 32'h1, 32'(faultIndicatorPin_b));
    ev(40);
    chk("filtered", 32'h0, 32'(faultIndicatorPin_b));
    clr();
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial begin
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    t_regs();
    t_thr();
    t_latch();
    t_retry();
    t_dis();
    t_filt();
    summarize();
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    nErrors++;
    summarize();
  end
endmodule // clf_top_tb

bind clf_top clf_top_chk #(.RETRY_UNIT_CYCLES(RETRY_UNIT_CYCLES)) i_clf_top_chk (
  .core_clk(core_clk), .rst_b(rst_b), .address(address), .byteenable(byteenable),
  .read(read), .write(write), .writedata(writedata), .waitrequest(waitrequest),
  .faultIndicatorPin_b(faultIndicatorPin_b), .bridgeState(bridgeState),
  .detectDisabled(detectDisabled), .absentMotorThreshold(absentMotorThreshold)
);
